// ---- desc_word_sel.sv ----
// one record descriptor flattened into its seven page words
module desc_word_sel
  import record_index_pkg::*;
(
  input wire record_desc_s desc, // stored descriptor
  input wire logic [2:0] word_idx, // word within descriptor, 0..6
  output logic [15:0] word // selected word
);
  always_comb
  begin
    unique case (word_idx)
      3'h0: word = desc.number;
      3'h1: word = desc.seconds[31:16];
      3'h2: word = desc.seconds[15:0];
      3'h3: word = desc.millis[31:16];
      3'h4: word = desc.millis[15:0];
      3'h5: word = {13'h0000, desc.cause};
      3'h6: word = desc.ack;
      default: word = WORD_RESET;
    endcase
  end
endmodule

// ---- disturbance_record_index_map.sv ----
// read-only disturbance record index page with shared field formatting
// Operation
// [R1] function 03 at base; word 1 record count
// [R2] word 2 holds oldest record number n
// [R3] oldest seconds words 3-4, then milliseconds
// [R4] cause codes: trip, instant, remote, input
// [R5] five seven-word descriptors, last ack word 36
// [R6] milliseconds follow seconds; n+3 words 26-27
// [R7] numeric fields unsigned 16-bit, 1..65535
// [R8] edit mode 0 idle, 1 active, 2 breaker
// [R9] direction 0 line, 1 bus, 2 none
// [R10] text word: two ASCII chars 32..127
// [R11] input flags bits 0-7, rest reserved
// [R12] stage disable bits 0-6, 8-11 only
// [R13] function disable bits 0-8 only
// [R14] location bits 1,2,3; others reserved
// [R15] other functions get illegal-function exception
module disturbance_record_index_map
  import record_index_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic srst, // synchronous reset, active high
  input wire logic req_valid, // one request word this cycle
  input wire read_req_s req, // function code and word address
  output read_rsp_s rsp, // registered answer
  output logic rsp_valid, // answer valid pulse
  input wire logic rec_load, // recorder updates the stored list
  input wire logic [7:0] rec_count, // records available
  input wire record_desc_s rec_desc [DESC_COUNT], // oldest first
  input wire logic [1:0] edit_state_in, // raw editing state
  input wire logic [1:0] direction_in, // raw forward direction
  input wire logic [7:0] text_char0, // first character
  input wire logic [7:0] text_char1, // second character
  input wire logic [7:0] logic_inputs, // logic inputs 1..8
  input wire logic [15:0] stage_disable_in, // raw stage disable flags
  input wire logic [8:0] function_disable_in, // raw function disable flags
  input wire logic [2:0] location_in, // both, remote, local
  input wire logic [15:0] numeric_in, // raw numeric setting
  output logic [15:0] fmt_numeric, // numeric field word
  output logic numeric_illegal, // numeric value out of range
  output logic [15:0] fmt_editing_state, // edit mode word
  output logic [15:0] fmt_forward_direction, // direction word
  output logic [15:0] fmt_text_pair, // ASCII pair word
  output logic [15:0] fmt_input_flags, // binary input word
  output logic [15:0] fmt_current_stage_disable, // stage disable word
  output logic [15:0] fmt_function_disable, // function disable word
  output logic [15:0] fmt_control_location // local/remote word
);
  localparam logic [15:0] STAGE_MASK = 16'h0f7f;
  localparam logic [15:0] FUNC_MASK = 16'h01ff;

  // stored page contents; only refreshed as a whole so a read never mixes two snapshots
  logic [7:0] count_reg, count_next;
  record_desc_s desc_reg [DESC_COUNT];
  record_desc_s desc_next [DESC_COUNT];
  read_rsp_s rsp_reg, rsp_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [15:0] fmt_reg [8];
  logic [15:0] fmt_next [8];
  logic illegal_reg, illegal_next;

  logic [15:0] word_off;
  logic [15:0] desc_off;
  logic [2:0] desc_sel;
  logic [2:0] word_sel;
  logic [15:0] desc_words [DESC_COUNT];
  logic in_page;

  genvar g;
  generate
    for (g = 0; g < DESC_COUNT; g++)
    begin : gen_desc
      desc_word_sel u_sel
      (
        .desc(desc_reg[g]),
        .word_idx(word_sel),
        .word(desc_words[g])
      );
    end
  endgenerate

  always_comb
  begin
    word_off = req.addr - PAGE_BASE;
    in_page = (req.addr >= PAGE_BASE) && (word_off < 16'(PAGE_WORDS));
    desc_off = word_off - 16'(DESC_FIRST_WORD);
    desc_sel = 3'(desc_off / 16'(DESC_WORDS)); // [R5]
    word_sel = 3'(desc_off % 16'(DESC_WORDS)); // [R3] [R6]
  end

  always_comb
  begin
    count_next = count_reg;
    desc_next = desc_reg;
    if (rec_load)
    begin
      count_next = rec_count;
      for (int i = 0; i < DESC_COUNT; i++)
      begin
        desc_next[i] = rec_desc[i];
        // unknown codes are stored as zero rather than passed on
        if (rec_desc[i].cause > CAUSE_INPUT) // [R4]
        begin
          desc_next[i].cause = CAUSE_NONE;
        end
      end
    end
  end

  always_comb
  begin
    rsp_next = '{exc: 1'b0, code: 8'h00, data: WORD_RESET};
    rsp_valid_next = req_valid;
    if (req_valid)
    begin
      if (req.func != FN_READ_WORDS) // [R15]
      begin
        rsp_next.exc = 1'b1;
        rsp_next.code = EXC_ILLEGAL_FUNCTION;
        rsp_next.data = {8'h00, req.func | EXC_FLAG};
      end
      else if (!in_page)
      begin
        rsp_next.exc = 1'b1;
        rsp_next.code = EXC_ILLEGAL_ADDRESS;
        rsp_next.data = {8'h00, req.func | EXC_FLAG};
      end
      else if (word_off == 16'h0000)
      begin
        rsp_next.data = {8'h00, count_reg}; // [R1]
      end
      else if (word_off == 16'h0001)
      begin
        rsp_next.data = desc_reg[0].number; // [R2]
      end
      else
      begin
        rsp_next.data = desc_words[desc_sel]; // [R5]
      end
    end
  end

  // field formatting: out-of-range encodings report the documented neutral value
  always_comb
  begin
    illegal_next = (numeric_in == 16'h0000); // [R7]
    fmt_next[0] = numeric_in; // [R7]
    fmt_next[1] = (edit_state_in > EDIT_PANEL_BREAKER) ? 16'h0000 : {14'h0000, edit_state_in}; // [R8]
    fmt_next[2] = (direction_in > DIR_NONE) ? {14'h0000, DIR_NONE} : {14'h0000, direction_in}; // [R9]
    // codes below 32 and the upper half both read as space so the word stays within 32..127
    fmt_next[3] = {(text_char0 < ASCII_MIN || text_char0 > ASCII_MAX) ? ASCII_SPACE : text_char0,
                   (text_char1 < ASCII_MIN || text_char1 > ASCII_MAX) ? ASCII_SPACE : text_char1}; // [R10]
    fmt_next[4] = {8'h00, logic_inputs}; // [R11]
    fmt_next[5] = stage_disable_in & STAGE_MASK; // [R12]
    fmt_next[6] = {7'h00, function_disable_in} & FUNC_MASK; // [R13]
    fmt_next[7] = 16'h0000;
    fmt_next[7][LOC_BOTH_BIT] = location_in[0]; // [R14]
    fmt_next[7][LOC_REMOTE_BIT] = location_in[1]; // [R14]
    fmt_next[7][LOC_LOCAL_BIT] = location_in[2]; // [R14]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_reg <= COUNT_RESET;
      rsp_reg <= '{exc: 1'b0, code: 8'h00, data: WORD_RESET};
      rsp_valid_reg <= 1'b0;
      illegal_reg <= 1'b0;
      for (int i = 0; i < DESC_COUNT; i++)
      begin
        desc_reg[i] <= '0;
      end
      for (int i = 0; i < 8; i++)
      begin
        fmt_reg[i] <= WORD_RESET;
      end
    end
    else
    begin
      count_reg <= count_next;
      desc_reg <= desc_next;
      rsp_reg <= rsp_next;
      rsp_valid_reg <= rsp_valid_next;
      illegal_reg <= illegal_next;
      fmt_reg <= fmt_next;
    end
  end

  assign rsp = rsp_reg;
  assign rsp_valid = rsp_valid_reg;
  assign fmt_numeric = fmt_reg[0];
  assign numeric_illegal = illegal_reg;
  assign fmt_editing_state = fmt_reg[1];
  assign fmt_forward_direction = fmt_reg[2];
  assign fmt_text_pair = fmt_reg[3];
  assign fmt_input_flags = fmt_reg[4];
  assign fmt_current_stage_disable = fmt_reg[5];
  assign fmt_function_disable = fmt_reg[6];
  assign fmt_control_location = fmt_reg[7];

  // assertions
  sequence s_read_count;
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE;
  endsequence

  a_count_word_read: assert property (@(posedge clk) disable iff (srst) // [R1]
    s_read_count |=> rsp_valid && !rsp.exc && rsp.data == {8'h00, $past(count_reg)})
    else $error("count word wrong");

  a_oldest_number_word: assert property (@(posedge clk) disable iff (srst) // [R2]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0001
    |=> rsp.data == $past(desc_reg[0].number))
    else $error("oldest number wrong");

  a_oldest_seconds_hi: assert property (@(posedge clk) disable iff (srst) // [R3]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0002
    |=> rsp.data == $past(desc_reg[0].seconds[31:16]))
    else $error("oldest seconds wrong");

  a_cause_range_kept: assert property (@(posedge clk) disable iff (srst) // [R4]
    desc_reg[0].cause <= CAUSE_INPUT && desc_reg[4].cause <= CAUSE_INPUT)
    else $error("cause out of range");

  a_last_ack_word: assert property (@(posedge clk) disable iff (srst) // [R5]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0023
    |=> rsp.data == $past(desc_reg[4].ack))
    else $error("last ack wrong");

  a_millis_n3_low: assert property (@(posedge clk) disable iff (srst) // [R6]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h001a
    |=> rsp.data == $past(desc_reg[3].millis[15:0]))
    else $error("n+3 millis wrong");

  a_numeric_zero_flag: assert property (@(posedge clk) disable iff (srst) // [R7]
    numeric_in == 16'h0000 |=> numeric_illegal)
    else $error("zero numeric not flagged");

  a_stage_reserved_zero: assert property (@(posedge clk) disable iff (srst) // [R12]
    (fmt_current_stage_disable & ~STAGE_MASK) == 16'h0000 && fmt_function_disable[15:9] == 7'h00)
    else $error("reserved disable bits set");

  a_bad_function_exc: assert property (@(posedge clk) disable iff (srst) // [R15]
    req_valid && req.func != FN_READ_WORDS
    |=> rsp_valid && rsp.exc && rsp.code == EXC_ILLEGAL_FUNCTION)
    else $error("missing illegal function exception");

  a_location_reserved: assert property (@(posedge clk) disable iff (srst) // [R14]
    fmt_control_location[15:4] == 12'h000 && !fmt_control_location[0])
    else $error("location reserved bits set");

  sequence s_read_outside;
    req_valid && req.func == FN_READ_WORDS && (req.addr < PAGE_BASE || req.addr > PAGE_BASE + 16'h0023);
  endsequence

  a_bad_address_exc: assert property (@(posedge clk) disable iff (srst) // [R1]
    s_read_outside |=> rsp_valid && rsp.exc && rsp.code == EXC_ILLEGAL_ADDRESS)
    else $error("missing illegal address exception");

  a_answer_one_cycle: assert property (@(posedge clk) disable iff (srst) // [R1]
    !srst |=> rsp_valid == $past(req_valid))
    else $error("answer not one cycle after request");

  a_oldest_seconds_lo: assert property (@(posedge clk) disable iff (srst) // [R3]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0003
    |=> rsp.data == $past(desc_reg[0].seconds[15:0]))
    else $error("oldest seconds low wrong");

  a_oldest_millis_hi: assert property (@(posedge clk) disable iff (srst) // [R3]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0004
    |=> rsp.data == $past(desc_reg[0].millis[31:16]))
    else $error("oldest millis wrong");

  a_next_number_word: assert property (@(posedge clk) disable iff (srst) // [R5]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0008
    |=> rsp.data == $past(desc_reg[1].number))
    else $error("n+1 number wrong");

  a_millis_n3_high: assert property (@(posedge clk) disable iff (srst) // [R6]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0019
    |=> rsp.data == $past(desc_reg[3].millis[31:16]))
    else $error("n+3 millis high wrong");

  a_cause_word_n4: assert property (@(posedge clk) disable iff (srst) // [R4]
    req_valid && req.func == FN_READ_WORDS && req.addr == PAGE_BASE + 16'h0022
    |=> rsp.data == {13'h0000, $past(desc_reg[4].cause)})
    else $error("n+4 cause wrong");

  a_edit_mode_range: assert property (@(posedge clk) disable iff (srst) // [R8]
    fmt_editing_state <= 16'h0002)
    else $error("edit mode out of range");

  a_direction_range: assert property (@(posedge clk) disable iff (srst) // [R9]
    fmt_forward_direction <= 16'h0002)
    else $error("direction out of range");

  a_text_printable: assert property (@(posedge clk) disable iff (srst) // [R10]
    !srst |=> fmt_text_pair[15:8] >= ASCII_MIN && fmt_text_pair[15:8] <= ASCII_MAX
    && fmt_text_pair[7:0] >= ASCII_MIN && fmt_text_pair[7:0] <= ASCII_MAX)
    else $error("text pair not printable");

  a_input_flags_map: assert property (@(posedge clk) disable iff (srst) // [R11]
    !srst |=> fmt_input_flags == {8'h00, $past(logic_inputs)})
    else $error("input flags wrong");

  a_function_flags_map: assert property (@(posedge clk) disable iff (srst) // [R13]
    !srst |=> fmt_function_disable == {7'h00, $past(function_disable_in)})
    else $error("function disable flags wrong");
endmodule

// ---- record_index_pkg.sv ----
// package: page layout, field encodings and reset values for the disturbance record index page
package record_index_pkg;
  localparam logic [15:0] PAGE_BASE = 16'h3d00;
  localparam int PAGE_WORDS = 36;
  localparam int DESC_WORDS = 7;
  localparam int DESC_COUNT = 5;
  // offset of the oldest record number; each descriptor then takes seven words
  localparam int DESC_FIRST_WORD = 1;
  localparam logic [7:0] FN_READ_WORDS = 8'h03;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  typedef enum logic [2:0]
  {
    CAUSE_NONE = 3'h0,
    CAUSE_TRIP = 3'h1,
    CAUSE_INST = 3'h2,
    CAUSE_REMOTE = 3'h3,
    CAUSE_INPUT = 3'h4
  } cause_e;

  typedef enum logic [1:0]
  {
    EDIT_IDLE = 2'h0,
    EDIT_ACTIVE = 2'h1,
    EDIT_PANEL_BREAKER = 2'h2
  } fmt_editing_state_e;

  typedef enum logic [1:0]
  {
    DIR_LINE = 2'h0,
    DIR_BUS = 2'h1,
    DIR_NONE = 2'h2
  } fmt_forward_direction_e;

  localparam int LOC_BOTH_BIT = 1;
  localparam int LOC_REMOTE_BIT = 2;
  localparam int LOC_LOCAL_BIT = 3;
  localparam logic [7:0] ASCII_MIN = 8'h20;
  localparam logic [7:0] ASCII_MAX = 8'h7f;
  localparam logic [7:0] ASCII_SPACE = 8'h20;

  // one stored record descriptor as captured by the recorder
  typedef struct packed
  {
    logic [15:0] number;
    logic [31:0] seconds;
    logic [31:0] millis;
    cause_e cause;
    logic [15:0] ack;
  } record_desc_s;

  // one word-read request from the protocol engine
  typedef struct packed
  {
    logic [7:0] func;
    logic [15:0] addr;
  } read_req_s;

  // answer to one request word
  typedef struct packed
  {
    logic exc;
    logic [7:0] code;
    logic [15:0] data;
  } read_rsp_s;
endpackage

// ---- tb_top.sv ----
// self-checking bench for the disturbance record index page
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import record_index_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid, rsp_valid, numeric_illegal;
  logic rec_load = 1'b0;
  read_req_s req;
  read_rsp_s rsp, r;
  logic [7:0] rec_count, text_char0, text_char1, logic_inputs, count_exp, fn;
  record_desc_s rec_desc [DESC_COUNT];
  record_desc_s desc_exp [DESC_COUNT];
  logic [1:0] edit_state_in, direction_in;
  logic [15:0] stage_disable_in, numeric_in;
  logic [8:0] function_disable_in;
  logic [2:0] location_in;
  logic [15:0] f_num, f_edit, f_dir, f_text, f_in, f_stage, f_func, f_loc;
  logic [15:0] bad [3] = '{16'h3cff, 16'h3d24, 16'h0000};
  logic [31:0] seed = 32'hf342;
  int ord[$];
  int fails = 0, n_tests = 0, cycles = 0;

  disturbance_record_index_map u_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req), .rsp(rsp),
    .rsp_valid(rsp_valid), .rec_load(rec_load), .rec_count(rec_count), .rec_desc(rec_desc),
    .edit_state_in(edit_state_in), .direction_in(direction_in), .text_char0(text_char0), .text_char1(text_char1),
    .logic_inputs(logic_inputs), .stage_disable_in(stage_disable_in), .function_disable_in(function_disable_in),
    .location_in(location_in), .numeric_in(numeric_in), .fmt_numeric(f_num), .numeric_illegal(numeric_illegal),
    .fmt_editing_state(f_edit), .fmt_forward_direction(f_dir), .fmt_text_pair(f_text), .fmt_input_flags(f_in),
    .fmt_current_stage_disable(f_stage), .fmt_function_disable(f_func), .fmt_control_location(f_loc));
  word_read_master u_master (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req), .rsp(rsp),
    .rsp_valid(rsp_valid));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ascii(input logic [7:0] c);
    return (c < 8'h20 || c > 8'h7f) ? 8'h20 : c;
  endfunction
  function automatic logic [15:0] page_word(input int o);
    record_desc_s d;
    logic [15:0] w [7];
    if (o == 0)
      return {8'h00, count_exp};
    d = desc_exp[(o - 1) / 7];
    w = '{d.number, d.seconds[31:16], d.seconds[15:0], d.millis[31:16], d.millis[15:0], {13'h0, d.cause}, d.ack};
    return w[(o - 1) % 7];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic ask(input logic [7:0] f, input logic [15:0] a);
    u_master.send(f, a);
    u_master.idle(1);
    r = u_master.got.pop_front();
  endtask

  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      print_verdict();
    end
  end

  initial
  begin
    {rec_count, text_char0, text_char1, logic_inputs, edit_state_in, direction_in} = '0;
    {stage_disable_in, numeric_in, function_disable_in, location_in} = '0;
    rec_desc = '{default: '0};
    repeat (8) @(posedge clk);
    #2;
    srst = 1'b0;
    // three passes: in order back to back, random order with gaps, reverse back to back
    for (int k = 0; k < 3; k++)
    begin
      count_exp = 8'(rnd());
      rec_count = count_exp;
      for (int i = 0; i < DESC_COUNT; i++)
      begin
        {desc_exp[i].number, desc_exp[i].ack} = rnd();
        desc_exp[i].seconds = rnd();
        desc_exp[i].millis = rnd();
        desc_exp[i].cause = cause_e'(3'(1 + (i + k) % 4));
      end
      rec_desc = desc_exp;
      rec_load = 1'b1;
      @(posedge clk);
      #2;
      rec_load = 1'b0;
      rec_count = ~count_exp;
      foreach (rec_desc[j])
        rec_desc[j] = record_desc_s'(~desc_exp[j]);
      for (int i = 0; i < PAGE_WORDS; i++)
      begin
        ord.push_back((k == 1) ? int'(rnd() % PAGE_WORDS) : ((k == 0) ? i : PAGE_WORDS - 1 - i));
        u_master.send(FN_READ_WORDS, PAGE_BASE + 16'(ord[$]));
        if (k == 1)
          u_master.idle(int'(1 + rnd() % 2));
      end
      u_master.idle(2);
      check(u_master.got.size(), ord.size());
      foreach (ord[j])
      begin
        r = u_master.got.pop_front();
        check({r.exc, r.code, r.data}, {9'h0, page_word(ord[j])});
      end
      ord.delete();
    end
    for (int i = 0; i < 8; i++)
    begin
      fn = 8'(rnd()) & 8'h7f;
      if (fn == FN_READ_WORDS)
        fn = 8'h10;
      ask(fn, PAGE_BASE + 16'(i));
      check({r.exc, r.code, r.data}, {1'b1, EXC_ILLEGAL_FUNCTION, 8'h00, fn | EXC_FLAG});
    end
    foreach (bad[i])
    begin
      ask(FN_READ_WORDS, bad[i]);
      check({r.exc, r.code}, {1'b1, EXC_ILLEGAL_ADDRESS});
    end
    for (int i = 0; i < 40; i++)
    begin
      edit_state_in = (i < 4) ? 2'(i) : 2'(rnd());
      direction_in = (i < 4) ? 2'(i) : 2'(rnd());
      text_char0 = (i == 0) ? 8'h1f : ((i == 2) ? 8'hff : 8'h20 + 8'(rnd() % 96));
      text_char1 = (i == 1) ? 8'h00 : ((i == 3) ? 8'h80 : 8'h20 + 8'(rnd() % 96));
      logic_inputs = 8'(rnd());
      stage_disable_in = (i == 2) ? 16'hffff : 16'(rnd());
      function_disable_in = (i == 2) ? 9'h1ff : 9'(rnd());
      location_in = 3'(rnd());
      numeric_in = (i == 3) ? 16'h0000 : ((i == 4) ? 16'hffff : 16'(rnd()));
      @(posedge clk);
      #2;
      check(f_edit, (edit_state_in > 2'h2) ? 16'h0000 : {14'h0, edit_state_in});
      check(f_dir, {14'h0, (direction_in > 2'h2) ? 2'h2 : direction_in});
      check(f_text, {ascii(text_char0), ascii(text_char1)});
      check(f_in, {8'h00, logic_inputs});
      check(f_stage, stage_disable_in & 16'h0f7f);
      check(f_func, {7'h00, function_disable_in});
      check(f_loc, {12'h000, location_in, 1'b0});
      check({numeric_illegal, f_num}, {numeric_in == 16'h0000, numeric_in});
    end
    srst = 1'b1;
    @(posedge clk);
    #2;
    check({rsp_valid, f_stage}, 17'h0);
    check({f_text, f_in}, 32'h0);
    srst = 1'b0;
    ask(FN_READ_WORDS, PAGE_BASE);
    check({r.exc, r.data}, 17'h0);
    check(u_master.late, 0);
    print_verdict();
  end
endmodule

// ---- word_read_master.sv ----
// word-read master model: issues page requests and collects the answers
module word_read_master
  import record_index_pkg::*;
(
  input wire logic clk, // bench clock
  input wire logic srst, // bench reset
  output logic req_valid, // request pulse
  output read_req_s req, // function and address
  input wire read_rsp_s rsp, // device answer
  input wire logic rsp_valid // answer pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  read_rsp_s got[$];
  logic was_req = 1'b0;
  int late = 0;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // one word per taking edge; back-to-back calls keep the strobe high
  task automatic send(input logic [7:0] func, input logic [15:0] addr);
    req_valid = 1'b1;
    req = '{func: func, addr: addr};
    @(posedge clk);
    #2;
  endtask
  // idle bus is inverted so a stale request never looks valid
  task automatic idle(input int n);
    req_valid = 1'b0;
    req = ~req;
    repeat (n)
    begin
      @(posedge clk);
      #2;
    end
  endtask
  always @(posedge clk)
  begin
    if (!srst && rsp_valid !== was_req)
      late++;
    if (rsp_valid === 1'b1)
      got.push_back(rsp);
    was_req <= req_valid;
  end
endmodule
